// [pkg/fspc_defs.vh]
// Constants for the five-stage pipeline hazard control block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef FSPC_DEFS_VH
`define FSPC_DEFS_VH

// Stage indices in the valid and exception vectors.
`define FSPC_STG_I        3'h0
`define FSPC_STG_R        3'h1
`define FSPC_STG_A        3'h2
`define FSPC_STG_D        3'h3
`define FSPC_STG_W        3'h4

// Exception cause codes carried down the pipeline.
`define FSPC_EXC_NONE     5'h00
`define FSPC_EXC_IFETCH   5'h01
`define FSPC_EXC_RESV     5'h0A
`define FSPC_EXC_EXEC     5'h0C
`define FSPC_EXC_DATA     5'h04

// Default exception vector and reset fetch address.
`define FSPC_EXC_VECTOR   32'h80000180
`define FSPC_RESET_PC     32'hBFC00000
`define FSPC_PC_STEP      32'h00000004

// Data miss refill states.
`define FSPC_DM_IDLE      2'h0
`define FSPC_DM_VICTIM    2'h1
`define FSPC_DM_REFILL    2'h2

// Instruction miss refill states.
`define FSPC_IM_IDLE      1'h0
`define FSPC_IM_FILL      1'h1

// Words per cache line.
`define FSPC_LINE_WORDS   3'h4

`endif

// [verilog/fspc_stage_reg.v]
// Flip-flop bank holding one pipeline stage word with a hold and a flush.
// Assumes one clock REF_CLK domain and a synchronous active-low reset.
`default_nettype none

module fspc_stage_reg
#(
   parameter W = 8
)
(
   input  wire         clk,
   input  wire         rst_n,
   input  wire         hold,
   input  wire         flush,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);

   // Flush wins over hold so a killed slot can never stay live.
   always @(posedge clk)
   begin
      if (!rst_n || flush)
      begin
         q <= {W{1'b0}};
      end
      else if (!hold)
      begin
         q <= d;
      end
   end

endmodule // fspc_stage_reg

`default_nettype wire

// [verilog/fspc_pipe_ctrl.v]
// Hazard, stall, slip and exception control for a five-stage integer pipeline.
// Assumes the caches, write buffer and decoder sit outside, all on REF_CLK.
// How it works
// - ALU and load results write in late W
// - W first resolves exceptions before any write
// - Branch decides in A; target fetched next
// - Fetch both paths, then keep chosen one
// - Load data forwarded after one delay slot
// - Conditions checked per stage; reserved fault in R
// - Exception cancels instruction and younger ones
// - At W record state, vector, clear flags
// - Older complete, younger not; program order
// - Late conditions stall the whole pipeline
// - Data miss in D; dirty victim buffered next
// - Data miss restarts on first doubleword
// - Issue only with operands and resources ready
// - Slip retries; D and W advance, bubbles
// - Killed instructions never cause a slip
// - Instruction miss seen in R, slips A
// - Instruction miss waits for whole line
// - Never write stores into instruction cache
// - Branch-likely not taken nullifies delay slot
`default_nettype none
`include "fspc_defs.vh"

module fspc_pipe_ctrl
(
   input  wire        REF_CLK,
   input  wire        RESET_N,
   input  wire        FETCH_VALID,
   input  wire        IMISS_R,
   input  wire        IFETCH_FAULT,
   input  wire        RESV_INSTR,
   input  wire        EXEC_FAULT,
   input  wire        DATA_FAULT,
   input  wire        IS_BRANCH,
   input  wire        IS_LIKELY,
   input  wire        IS_EXCEPTION_RETURN_INSTRUCTION,
   input  wire        IS_LOAD,
   input  wire        IS_STORE,
   input  wire        WRITES_REG,
   input  wire [4:0]  DEST_REG,
   input  wire [4:0]  SRC_A,
   input  wire [4:0]  SRC_B,
   input  wire        RESOURCE_BUSY,
   input  wire        BRANCH_TAKEN,
   input  wire [31:0] BRANCH_TARGET,
   input  wire [31:0] EXCEPTION_RETURN_TARGET,
   input  wire [31:0] INSTR_PC,
   input  wire        DMISS_D,
   input  wire        VICTIM_DIRTY,
   input  wire        REFILL_FIRST,
   input  wire        IFILL_WORD,
   output reg  [31:0] FETCH_PC,
   output reg  [31:0] ALT_PC,
   output wire        ALT_FETCH,
   output wire        STALL,
   output wire        SLIP,
   output wire        REG_WRITE,
   output reg  [4:0]  REG_WRITE_ADDR,
   output wire [1:0]  FWD_SEL_A,
   output wire [1:0]  FWD_SEL_B,
   output wire        VICTIM_TO_WBUF,
   output wire        ICACHE_STORE_WE,
   output reg         EXC_TAKEN,
   output reg  [4:0]  EXC_CAUSE,
   output reg  [31:0] EXCEPTION_RETURN_PC,
   output reg         IN_DELAY_SLOT,
   output wire        STAGE_PHASE
);

   // Stage word: {valid, exc, cause[4:0], spare, wreg, load, br, dest[4:0], pc[31:0]}.
   localparam SW = 48;

   wire [SW-1:0] r_q;
   wire [SW-1:0] a_q;
   wire [SW-1:0] d_q;
   wire [SW-1:0] w_q;
   reg  [SW-1:0] r_d;
   reg  [SW-1:0] a_d;
   reg  [SW-1:0] d_d;

   reg  [1:0]  dm_state_q;
   reg  [1:0]  dm_state_d;
   reg         im_state_q;
   reg  [2:0]  im_cnt_q;
   reg         phase_q;
   reg         slot_q;
   reg         likely_q;
   reg         alt_q;
   reg         w_is_br_q;

   wire r_v  = r_q[47];
   wire a_v  = a_q[47];
   wire d_v  = d_q[47];
   wire w_v  = w_q[47];
   wire a_ex = a_q[46];
   wire d_ex = d_q[46];
   wire w_ex = w_q[46];

   // Operand match against an older stage that writes a register.
   function fwd_hit;
      input [4:0]    src;
      input [SW-1:0] s;
      begin
         fwd_hit = s[47] && !s[46] && s[39] && (s[36:32] == src) && (src != 5'h00);
      end
   endfunction

   // Forward select: 01 from A result, 10 from D data, 00 register file.
   // Stage words come in as arguments so the select follows every stage change.
   function [1:0] fwd_pick;
      input [4:0]    src;
      input [SW-1:0] a;
      input [SW-1:0] d;
      begin
         if (fwd_hit(src, a) && !a[38])
            fwd_pick = 2'h1;
         else if (fwd_hit(src, d))
            fwd_pick = 2'h2;
         else
            fwd_pick = 2'h0;
      end
   endfunction

   // Exception leaving W redirects and kills everything younger.
   wire exc_w = w_v && w_ex;

   // A load in A cannot feed the next instruction; that slot must wait.
   wire load_use = a_v && !a_ex && a_q[38] &&
                   (fwd_hit(SRC_A, a_q) || fwd_hit(SRC_B, a_q));

   // Cancelled or reserved instructions in R, or a faulting fetch in I, raise no interlock.
   wire r_live = r_v && !exc_w && !(IFETCH_FAULT || RESV_INSTR);

   // Stall freezes everything while a data miss waits for its first doubleword.
   assign STALL = (d_v && !d_ex && DMISS_D && !exc_w) ||
                  (dm_state_q != `FSPC_DM_IDLE && !REFILL_FIRST);

   // Slip holds I and R; the R-stage miss holds the A slot empty.
   assign SLIP = !STALL && r_live &&
                 (load_use || RESOURCE_BUSY || IMISS_R ||
                  im_state_q == `FSPC_IM_FILL);

   // Dirty victim goes to the write buffer the cycle after the miss.
   assign VICTIM_TO_WBUF = (dm_state_q == `FSPC_DM_VICTIM);

   // The instruction cache only receives refills.
   assign ICACHE_STORE_WE = 1'b0;

   // W writes only for clean results, never branches or flagged ones.
   assign REG_WRITE = w_v && !w_ex && w_q[39] && !w_is_br_q && phase_q;

   assign FWD_SEL_A = fwd_pick(SRC_A, a_q, d_q);
   assign FWD_SEL_B = fwd_pick(SRC_B, a_q, d_q);
   assign ALT_FETCH = alt_q;
   assign STAGE_PHASE = phase_q;

   // Next stage words with cancellation and bubble insertion.
   always @*
   begin
      r_d = {SW{1'b0}};
      a_d = {SW{1'b0}};
      d_d = d_q;
      if (FETCH_VALID && !(slot_q && likely_q && !BRANCH_TAKEN))
      begin
         r_d = {1'b1, IFETCH_FAULT, IFETCH_FAULT ? `FSPC_EXC_IFETCH : `FSPC_EXC_NONE,
                1'b0, WRITES_REG, IS_LOAD, IS_BRANCH, DEST_REG, INSTR_PC};
      end
      if (!SLIP)
      begin
         a_d = r_q;
         if (r_v && RESV_INSTR && !r_q[46])
         begin
            a_d[46]    = 1'b1;
            a_d[45:41] = `FSPC_EXC_RESV;
         end
      end
      d_d = a_q;
      if (a_v && !a_ex && EXEC_FAULT)
      begin
         d_d[46]    = 1'b1;
         d_d[45:41] = `FSPC_EXC_EXEC;
      end
   end

   // Late data fault marks the D instruction; older fault in W still wins.
   wire [SW-1:0] w_in = (d_v && !d_ex && DATA_FAULT) ?
                        {d_q[47], 1'b1, `FSPC_EXC_DATA, d_q[40:0]} : d_q;

   fspc_stage_reg #(.W(SW)) u_r (.clk(REF_CLK), .rst_n(RESET_N),
      .hold(STALL || SLIP), .flush(exc_w), .d(r_d), .q(r_q));
   fspc_stage_reg #(.W(SW)) u_a (.clk(REF_CLK), .rst_n(RESET_N),
      .hold(STALL), .flush(exc_w), .d(a_d), .q(a_q));
   fspc_stage_reg #(.W(SW)) u_d (.clk(REF_CLK), .rst_n(RESET_N),
      .hold(STALL), .flush(exc_w), .d(d_d), .q(d_q));
   fspc_stage_reg #(.W(SW)) u_w (.clk(REF_CLK), .rst_n(RESET_N),
      .hold(STALL), .flush(exc_w), .d(w_in), .q(w_q));

   // Data miss sequencer: victim move, then wait for the first doubleword.
   always @*
   begin
      dm_state_d = dm_state_q;
      case (dm_state_q)
         `FSPC_DM_IDLE:
            if (d_v && !d_ex && DMISS_D && !exc_w)
               dm_state_d = VICTIM_DIRTY ? `FSPC_DM_VICTIM : `FSPC_DM_REFILL;
         `FSPC_DM_VICTIM:
            dm_state_d = REFILL_FIRST ? `FSPC_DM_IDLE : `FSPC_DM_REFILL;
         `FSPC_DM_REFILL:
            if (REFILL_FIRST)
               dm_state_d = `FSPC_DM_IDLE;
         default:
            dm_state_d = `FSPC_DM_IDLE;
      endcase
   end

   // Sequencers, phase toggle, branch tracking and fetch address.
   always @(posedge REF_CLK)
   begin
      if (!RESET_N)
      begin
         dm_state_q          <= `FSPC_DM_IDLE;
         im_state_q          <= `FSPC_IM_IDLE;
         im_cnt_q            <= 3'h0;
         phase_q             <= 1'b0;
         slot_q              <= 1'b0;
         likely_q            <= 1'b0;
         alt_q               <= 1'b0;
         w_is_br_q           <= 1'b0;
         FETCH_PC            <= `FSPC_RESET_PC;
         ALT_PC              <= 32'h00000000;
         REG_WRITE_ADDR      <= 5'h00;
         EXC_TAKEN           <= 1'b0;
         EXC_CAUSE           <= `FSPC_EXC_NONE;
         EXCEPTION_RETURN_PC <= 32'h00000000;
         IN_DELAY_SLOT       <= 1'b0;
      end
      else
      begin
         dm_state_q <= dm_state_d;
         phase_q    <= ~phase_q;
         w_is_br_q      <= STALL ? w_is_br_q : d_q[37];
         REG_WRITE_ADDR <= STALL ? REG_WRITE_ADDR : d_q[36:32];
         // Whole line must arrive before the fetch side resumes.
         case (im_state_q)
            `FSPC_IM_IDLE:
               if (IMISS_R && r_live && !STALL)
               begin
                  im_state_q <= `FSPC_IM_FILL;
                  im_cnt_q   <= 3'h0;
               end
            `FSPC_IM_FILL:
               if (IFILL_WORD)
               begin
                  if (im_cnt_q == `FSPC_LINE_WORDS - 3'h1)
                     im_state_q <= `FSPC_IM_IDLE;
                  im_cnt_q <= im_cnt_q + 3'h1;
               end
            default:
               im_state_q <= `FSPC_IM_IDLE;
         endcase
         // Record exception state and vector when a flagged instruction retires.
         EXC_TAKEN <= exc_w;
         if (exc_w)
         begin
            EXC_CAUSE           <= w_q[45:41];
            EXCEPTION_RETURN_PC <= w_q[31:0];
            IN_DELAY_SLOT       <= w_is_br_q;
            FETCH_PC            <= `FSPC_EXC_VECTOR;
            slot_q              <= 1'b0;
            alt_q               <= 1'b0;
         end
         else if (!STALL && !SLIP)
         begin
            // Branch in A: both paths fetched after the slot, then one kept.
            slot_q   <= a_v && !a_ex && a_q[37];
            likely_q <= IS_LIKELY;
            if (slot_q)
            begin
               FETCH_PC <= BRANCH_TARGET;
               ALT_PC   <= FETCH_PC + `FSPC_PC_STEP;
               alt_q    <= 1'b1;
            end
            else if (alt_q)
            begin
               FETCH_PC <= BRANCH_TAKEN ? FETCH_PC + `FSPC_PC_STEP :
                           ALT_PC + `FSPC_PC_STEP;
               alt_q    <= 1'b0;
            end
            else if (r_v && IS_EXCEPTION_RETURN_INSTRUCTION)
               FETCH_PC <= EXCEPTION_RETURN_TARGET;
            else
               FETCH_PC <= FETCH_PC + `FSPC_PC_STEP;
         end
      end
   end

   // Stores are accepted only toward the data side.
   wire unused_ok = IS_STORE;

endmodule // fspc_pipe_ctrl

`default_nettype wire

// [sim/fspc_checker.sv]
// Concurrent checks on the ports of the pipeline control block.
// Assumes one clock domain and a synchronous active-low reset.
`default_nettype none
`include "fspc_defs.vh"
module fspc_checker
(
   input wire logic        REF_CLK,
   input wire logic        RESET_N,
   input wire logic        IMISS_R,
   input wire logic        DMISS_D,
   input wire logic        VICTIM_DIRTY,
   input wire logic        REFILL_FIRST,
   input wire logic        STALL,
   input wire logic        SLIP,
   input wire logic        REG_WRITE,
   input wire logic        STAGE_PHASE,
   input wire logic        VICTIM_TO_WBUF,
   input wire logic        ICACHE_STORE_WE,
   input wire logic        EXC_TAKEN,
   input wire logic [31:0] FETCH_PC
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   // A dirty data miss freezing the pipe, and the first refill word ending it.
   sequence s_dirty_miss;
      $rose(STALL) && DMISS_D && VICTIM_DIRTY;
   endsequence
   sequence s_refill_back;
      REFILL_FIRST && $past(STALL);
   endsequence
   // Timing of writes, exceptions, interlocks and reset.
   chk_write_late_phase: assert property (REG_WRITE |-> STAGE_PHASE)
      else $error("register write outside the second phase");
   chk_exc_one_pulse: assert property (EXC_TAKEN |=> !EXC_TAKEN)
      else $error("exception pulse longer than one cycle");
   chk_exc_vector_fetch: assert property (
      EXC_TAKEN |-> ##[0:1] (FETCH_PC == `FSPC_EXC_VECTOR))
      else $error("fetch not redirected to the vector");
   chk_victim_next: assert property (s_dirty_miss |=> VICTIM_TO_WBUF)
      else $error("dirty victim not moved to write buffer");
   chk_stall_ends: assert property (s_refill_back |-> !STALL)
      else $error("stall held after first refill word");
   chk_imiss_slip: assert property ($rose(IMISS_R) |-> ##[0:2] SLIP)
      else $error("instruction miss without slip");
   chk_no_istore: assert property (!ICACHE_STORE_WE)
      else $error("store write into instruction cache");
   chk_reset_quiet: assert property (@(posedge REF_CLK) disable iff (1'b0)
      !RESET_N |=> !STALL && !SLIP && !EXC_TAKEN && FETCH_PC == `FSPC_RESET_PC)
      else $error("outputs not cleared by reset");
endmodule // fspc_checker
bind fspc_pipe_ctrl fspc_checker u_chk (.*);
`default_nettype wire

// [sim/fspc_cache_model.sv]
// Behavioural model of the caches and write buffer facing the pipeline control.
// Assumes the bench raises a request for one clock; answers land 1 ns after an edge.
`default_nettype none
module fspc_cache_model
(
   input  wire logic       clk,
   input  wire logic       dmiss_go,
   input  wire logic       imiss_go,
   input  wire logic [3:0] lat,
   output var  logic       dmiss,
   output var  logic       dirty,
   output var  logic       refill_first,
   output var  logic       imiss,
   output var  logic       fill_word
);
   timeunit 1ns;
   timeprecision 1ps;
   // Dirty data miss held until the first doubleword, after a prompt or slow wait.
   initial
   begin
      {dmiss, dirty, refill_first} = 3'h0;
      forever
      begin
         @(posedge clk iff dmiss_go);
         #1 {dmiss, dirty} = 2'h3;
         repeat (lat) @(posedge clk);
         #1 {dmiss, dirty, refill_first} = 3'h1;
         @(posedge clk);
         #1 refill_first = 1'h0;
      end
   end
   // Instruction miss: a whole line of four words, the miss dropped with the last.
   initial
   begin
      {imiss, fill_word} = 2'h0;
      forever
      begin
         @(posedge clk iff imiss_go);
         #1 imiss = 1'h1;
         for (int w = 0; w < 4; w++)
         begin
            repeat (2) @(posedge clk);
            #1 {imiss, fill_word} = {w < 3, 1'h1};
            @(posedge clk);
            #1 fill_word = 1'h0;
         end
      end
   end
endmodule // fspc_cache_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench: pipeline control block against a cache model.
// Assumes design, checker and model are compiled before this file.
`default_nettype none
`include "fspc_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        REF_CLK, RESET_N, FETCH_VALID, IFETCH_FAULT, RESV_INSTR, EXEC_FAULT;
   logic        DATA_FAULT, IS_BRANCH, IS_LIKELY, IS_EXCEPTION_RETURN_INSTRUCTION, IS_LOAD, IS_STORE, WRITES_REG;
   logic        RESOURCE_BUSY, BRANCH_TAKEN, IMISS_R, DMISS_D, VICTIM_DIRTY, REFILL_FIRST;
   logic        IFILL_WORD, ALT_FETCH, STALL, SLIP, REG_WRITE, VICTIM_TO_WBUF, EXC_TAKEN;
   logic        ICACHE_STORE_WE, IN_DELAY_SLOT, STAGE_PHASE, dgo, igo;
   logic [1:0]  FWD_SEL_A, FWD_SEL_B;
   logic [3:0]  lat;
   logic [4:0]  DEST_REG, SRC_A, SRC_B, REG_WRITE_ADDR, EXC_CAUSE;
   logic [31:0] BRANCH_TARGET, EXCEPTION_RETURN_TARGET, INSTR_PC, FETCH_PC, ALT_PC;
   logic [31:0] EXCEPTION_RETURN_PC;
   int          num_errors = 0;
   int          num_checks = 0;
   fspc_pipe_ctrl uut (.*);
   fspc_cache_model u_mem (.clk(REF_CLK), .dmiss_go(dgo), .imiss_go(igo), .lat(lat),
      .dmiss(DMISS_D), .dirty(VICTIM_DIRTY), .refill_first(REFILL_FIRST),
      .imiss(IMISS_R), .fill_word(IFILL_WORD));
   // Clock at 40 MHz.
   initial
   begin
      REF_CLK = 1'h0;
      forever #12.5 REF_CLK = ~REF_CLK;
   end
   // Steps whole cycles and lets the edge updates settle.
   task automatic step(input int n);
      repeat (n) @(posedge REF_CLK);
      #2;
   endtask
   // Compares one value and counts the outcome.
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Waits a bounded number of cycles for a flag to reach a level.
   task automatic wait_v(input string nm, ref logic s, input logic v, input int lim);
      for (int k = 0; k < lim && s !== v; k++)
         step(1);
      cmp(nm, v, s);
   endtask
   // Holds reset two cycles and checks the cleared state.
   task automatic t_reset();
      RESET_N = 1'h0;
      step(2);
      cmp("reset_pc", `FSPC_RESET_PC, FETCH_PC);
      cmp("reset_exc", 0, EXC_TAKEN);
      RESET_N = 1'h1;
      $display("t_reset done");
   endtask
   // Streams loads and stores; results must reach the register file.
   task automatic t_flow();
      {FETCH_VALID, WRITES_REG, IS_LOAD, IS_STORE, DEST_REG} = {4'hF, 5'h03};
      wait_v("reg_write", REG_WRITE, 1'h1, 8);
      cmp("wr_addr", 32'h00000003, REG_WRITE_ADDR);
      cmp("istore_we", 0, ICACHE_STORE_WE);
      {IS_LOAD, IS_STORE} = 2'h0;
      $display("t_flow done");
   endtask
   // A busy resource slips the front end without a stall.
   task automatic t_busy();
      RESOURCE_BUSY = 1'h1;
      step(2);
      cmp("slip", 1, SLIP);
      cmp("slip_stall", 0, STALL);
      RESOURCE_BUSY = 1'h0;
      step(1);
      cmp("slip_off", 0, SLIP);
      $display("t_busy done");
   endtask
   // A load in A holds its user one slot; then D data and A results are bypassed.
   task automatic t_fwd();
      IS_LOAD = 1'h1;
      step(1);
      IS_LOAD = 1'h0;
      step(1);
      SRC_A = 5'h03;
      #1;
      cmp("load_slip", 1, SLIP);
      step(1);
      cmp("load_slip_off", 0, SLIP);
      cmp("fwd_load", 2'h2, FWD_SEL_A);
      step(1);
      cmp("fwd_alu", 2'h1, FWD_SEL_A);
      SRC_A = 5'h00;
      $display("t_fwd done");
   endtask
   // Reserved word, then fetch fault: cause and restart address recorded.
   task automatic t_exc();
      for (int k = 0; k < 2; k++)
      begin
         {INSTR_PC, RESV_INSTR, IFETCH_FAULT} = {32'h00001000, 1'h0, k == 1};
         step(1);
         {RESV_INSTR, IFETCH_FAULT, FETCH_VALID} = {k == 0, 2'h0};
         step(1);
         {INSTR_PC, RESV_INSTR, IFETCH_FAULT, FETCH_VALID} = {32'h00000100, 3'h1};
         wait_v("exc_taken", EXC_TAKEN, 1'h1, 10);
         cmp("exc_cause", k ? `FSPC_EXC_IFETCH : `FSPC_EXC_RESV, EXC_CAUSE);
         cmp("ret_pc", 32'h00001000, EXCEPTION_RETURN_PC);
         cmp("in_slot", 0, IN_DELAY_SLOT);
         step(3);
      end
      $display("t_exc done");
   endtask
   // Dirty data misses answered promptly and slowly.
   task automatic t_dmiss();
      for (int k = 0; k < 2; k++)
      begin
         {lat, dgo} = {k ? 4'h6 : 4'h1, 1'h1};
         step(1);
         dgo = 1'h0;
         wait_v("stall", STALL, 1'h1, 1);
         step(1);
         cmp("victim_wbuf", 1, VICTIM_TO_WBUF);
         wait_v("stall_off", STALL, 1'h0, 8);
         cmp("refill_first", 1, REFILL_FIRST);
         step(2);
      end
      $display("t_dmiss done");
   endtask
   // Instruction miss slips until the whole line is in.
   task automatic t_imiss();
      igo = 1'h1;
      step(1);
      igo = 1'h0;
      wait_v("imiss_slip", SLIP, 1'h1, 2);
      cmp("imiss_stall", 0, STALL);
      wait_v("imiss_done", SLIP, 1'h0, 16);
      cmp("line_whole", 0, IMISS_R);
      $display("t_imiss done");
   endtask
   // Taken ordinary branch, then untaken branch-likely: dual fetch, then one path.
   task automatic t_branch();
      logic [31:0] pc;
      for (int k = 0; k < 2; k++)
      begin
         {IS_BRANCH, IS_LIKELY, BRANCH_TAKEN} = {1'h1, k == 1, k == 0};
         BRANCH_TARGET = 32'h00004000;
         step(1);
         IS_BRANCH = 1'h0;
         step(2);
         pc = FETCH_PC;
         step(1);
         cmp("alt_fetch", 1, ALT_FETCH);
         cmp("target_pc", 32'h00004000, FETCH_PC);
         cmp("alt_pc", pc + 32'h00000004, ALT_PC);
         step(1);
         cmp("alt_done", 0, ALT_FETCH);
         cmp("path_pc", k ? pc + 32'h00000008 : 32'h00004004, FETCH_PC);
      end
      {IS_LIKELY, BRANCH_TAKEN} = 2'h0;
      $display("t_branch done");
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence.
   initial
   begin
      {FETCH_VALID, IFETCH_FAULT, RESV_INSTR, EXEC_FAULT, DATA_FAULT, IS_BRANCH} = '0;
      {IS_LIKELY, IS_EXCEPTION_RETURN_INSTRUCTION, IS_LOAD, IS_STORE, WRITES_REG, RESOURCE_BUSY} = '0;
      {BRANCH_TAKEN, dgo, igo, lat, DEST_REG, SRC_A, SRC_B} = '0;
      {BRANCH_TARGET, EXCEPTION_RETURN_TARGET, INSTR_PC} = '0;
      t_reset();
      t_flow();
      t_busy();
      t_fwd();
      t_exc();
      t_dmiss();
      t_imiss();
      t_branch();
      t_reset();
      tally_and_finish();
   end
   // Watchdog: 2000 cycles, far beyond the hundred or so cycles the tests need.
   initial
   begin
      #50000;
      num_errors++;
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
